//--- verilog/aosr_pkg.sv
// Package: constants and carriers for the ALU operand source resolver
//==========================================================
package aosr_pkg;
   //==========================================================
   // Source select map
   localparam logic [8:0] SEL_KC0_LO  = 9'h080;
   localparam logic [8:0] SEL_KC0_HI  = 9'h09F;
   localparam logic [8:0] SEL_KC1_LO  = 9'h0A0;
   localparam logic [8:0] SEL_KC1_HI  = 9'h0BF;
   localparam logic [8:0] SEL_ZERO    = 9'h0F8;
   localparam logic [8:0] SEL_ONE_F   = 9'h0F9;
   localparam logic [8:0] SEL_ONE_I   = 9'h0FA;
   localparam logic [8:0] SEL_MONE_I  = 9'h0FB;
   localparam logic [8:0] SEL_HALF_F  = 9'h0FC;
   localparam logic [8:0] SEL_LITERAL = 9'h0FD;
   localparam logic [8:0] SEL_PREV_V  = 9'h0FE;
   localparam logic [8:0] SEL_PREV_S  = 9'h0FF;
   //==========================================================
   // Constant values
   localparam logic [31:0] NAN_VALUE  = 32'h7FFFFFFF;
   localparam logic [31:0] VAL_ZERO   = 32'h00000000;
   localparam logic [31:0] VAL_ONE_F  = 32'h3F800000;
   localparam logic [31:0] VAL_HALF_F = 32'h3F000000;
   localparam logic [31:0] VAL_ONE_I  = 32'h00000001;
   localparam logic [31:0] VAL_MONE_I = 32'hFFFFFFFF;
   //==========================================================
   // Kinds, index modes, lock modes, limits
   localparam logic [2:0] K_GPR = 3'h0;
   localparam logic [2:0] K_KC  = 3'h1;
   localparam logic [2:0] K_CF  = 3'h2;
   localparam logic [2:0] K_PV  = 3'h3;
   localparam logic [2:0] K_PS  = 3'h4;
   localparam logic [2:0] K_LIT = 3'h5;
   localparam logic [2:0] K_INL = 3'h6;
   localparam logic [2:0] K_NONE = 3'h7;
   localparam logic [2:0] IDX_LOOP = 3'h4;
   localparam logic [1:0] LOCK_NONE = 2'h0;
   localparam logic [1:0] LOCK_ONE  = 2'h1;
   localparam logic [1:0] LOCK_TWO  = 2'h2;
   localparam logic signed [10:0] CF_LAST  = 11'sh0FF;
   localparam logic signed [10:0] KC1_LAST = 11'sh00F;
   localparam logic signed [10:0] KC2_LAST = 11'sh01F;
   localparam logic [1:0] AR_DELAY = 2'h2;
   localparam logic [5:0] LANE_LAST = 6'h3F;
   //==========================================================
   // APB map and reset values
   localparam logic [11:0] REG_CONFIG = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_STALLS = 12'h008;
   localparam logic [11:0] REG_OOB    = 12'h00C;
   localparam logic [6:0]  GPR_COUNT_RST = 7'h40;
   //==========================================================
   // Carriers
   typedef struct packed {
      logic [8:0] sel;
      logic       rel;
      logic [1:0] elem;
      logic       neg;
      logic       abs;
      logic [2:0] index_mode;
      logic       three_src;
      logic       two_src_enc;
      logic [1:0] src_num;
      logic       is_dest;
      logic       mem_read;
      logic       last;
      logic       per_lane;
   } aosr_op_t;
   typedef struct packed {
      logic [8:0] x;
      logic [8:0] y;
      logic [8:0] z;
      logic [8:0] w;
   } aosr_ar_t;
   typedef struct packed {
      logic [1:0] lock_mode;
      logic       alt;
      logic       paired_kind;
      logic [3:0] buf0;
      logic [3:0] buf1;
      logic [7:0] line0;
      logic [7:0] line1;
      logic       loop_rel0;
      logic       loop_rel1;
   } aosr_clause_t;
   typedef struct packed {
      logic [2:0]  kind;
      logic [8:0]  addr;
      logic [1:0]  elem;
      logic        rd;
      logic        wr;
      logic        use_const;
      logic [31:0] const_val;
      logic        oob;
      logic [3:0]  kc_buffer;
      logic [7:0]  kc_line;
      logic        alt_bank;
      logic [5:0]  lane;
      logic        lit_two;
      logic        neg;
      logic        abs;
   } aosr_res_t;
endpackage

//--- verilog/aosr_modifier.sv
// Input modifier stage: absolute value then negate on returned operand
`timescale 1ns/10ps
module aosr_modifier (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Raw operand in
   input  wire logic        in_valid,
   input  wire logic [31:0] in_data,
   input  wire logic        in_neg,
   input  wire logic        in_abs,
   input  wire logic        in_raw,
   // Modified operand out
   output logic             out_valid,
   output logic [31:0]      out_data
);
   logic [31:0] mag;
   logic [31:0] next_data;

   // Absolute first, then negate; substituted NaN passes untouched
   always_comb begin
      mag       = in_abs ? {1'b0, in_data[30:0]} : in_data;
      next_data = in_neg ? {~mag[31], mag[30:0]} : mag;
      if (in_raw) begin
         next_data = in_data;
      end
   end

   // Output register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data  <= 32'h00000000;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_data <= next_data;
         end
      end
   end
endmodule

//--- verilog/aosr_resolver.sv
// Operand source resolver: decode, relative index, bounds, fetch issue
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module aosr_resolver (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Clause control from the sequencer
   input  wire logic                  clause_start,
   input  wire logic                  clause_end,
   input  wire aosr_pkg::aosr_clause_t clause_cfg,
   // Index sources
   input  wire logic                  ar_load,
   input  wire aosr_pkg::aosr_ar_t    ar_value,
   input  wire logic [8:0]            loop_index,
   input  wire logic [8:0]            lane_index,
   output logic [5:0]                 lane_sel,
   // Operand request
   input  wire logic                  op_valid,
   input  wire aosr_pkg::aosr_op_t    op,
   output logic                       op_ready,
   // Storage request and return
   output logic                       res_valid,
   output aosr_pkg::aosr_res_t        res,
   input  wire logic                  ret_valid,
   input  wire logic [31:0]           ret_data,
   // Resolved operand
   output logic                       operand_valid,
   output logic [31:0]                operand_data
);
   import aosr_pkg::*;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b01,
      S_WFALL = 2'b10
   } aosr_state_t;

   aosr_state_t  state;
   aosr_state_t  next_state;
   aosr_clause_t clause;
   aosr_ar_t     ar;
   logic         ar_valid;
   logic [1:0]   ar_age;
   logic         clause_active;
   logic [6:0]   gpr_count;
   logic [15:0]  stall_count;
   logic [15:0]  oob_count;
   aosr_op_t     wf_op;
   logic [5:0]   lane;
   logic         uses_ar;
   logic         ar_stall;
   logic         accept;
   logic         start_wf;
   logic         issue;
   aosr_res_t    next_res;
   aosr_op_t     cur_op;
   logic [8:0]   lane_idx;
   logic         pend;
   logic         pend_const;
   logic         pend_raw;
   logic [31:0]  pend_val;
   logic         pend_neg;
   logic         pend_abs;
   logic         mod_valid;
   logic         apb_wr;
   logic         apb_rd;

   // Signed sum of a 9-bit base and a 9-bit signed index
   function automatic logic signed [10:0] idx_sum(input logic [8:0] base,
                                                  input logic [8:0] idx);
      idx_sum = $signed({2'b00, base}) + $signed({{2{idx[8]}}, idx});
   endfunction

   // Whether an operand draws its index from the address register
   function automatic logic needs_ar(input aosr_op_t o);
      needs_ar = o.rel && (o.index_mode != IDX_LOOP) &&
                 (o.sel[8] || (o.sel < SEL_KC0_LO));
   endfunction

   // Full decode of one operand; bounds are judged on the sum and, for registers, on the base,
   // before any storage read leaves the block
   function automatic aosr_res_t resolve(input aosr_op_t o,
                                         input aosr_ar_t a,
                                         input logic [8:0] lp,
                                         input logic [8:0] lidx,
                                         input logic [6:0] n,
                                         input aosr_clause_t c);
      aosr_res_t       r;
      logic [8:0]      idx;
      logic signed [10:0] s;
      logic [8:0]      off;
      logic            bank1;
      r = '0;
      r.elem = o.elem;
      r.neg  = o.neg;
      r.abs  = o.abs && !o.three_src;
      r.rd   = !o.is_dest;
      r.wr   = o.is_dest;
      idx = 9'h000;
      s   = 11'sh000;
      off = 9'h000;
      bank1 = 1'b0;
      if (o.two_src_enc && (o.src_num == 2'h2) && !o.is_dest) begin
         r.kind      = K_NONE;
         r.rd        = 1'b0;
         r.use_const = 1'b1;
         r.const_val = VAL_ZERO;
         r.neg       = 1'b0;
         r.abs       = 1'b0;
      end else if (o.sel[8]) begin
         // Constant file, 256 entries of four elements
         r.kind = K_CF;
         case (o.index_mode)
            3'h0: idx = a.x;
            3'h1: idx = a.y;
            3'h2: idx = a.z;
            3'h3: idx = a.w;
            default: idx = lp;
         endcase
         if (o.per_lane && o.index_mode != IDX_LOOP) begin
            idx = lidx;
         end
         s = o.rel ? idx_sum({1'b0, o.sel[7:0]}, idx)
                   : $signed({3'b000, o.sel[7:0]});
         r.addr = {1'b0, s[7:0]};
         r.alt_bank = c.alt && c.paired_kind;
         if (s < 0 || s > CF_LAST) begin
            r.oob       = 1'b1;
            r.rd        = 1'b0;
            r.use_const = 1'b1;
            r.const_val = NAN_VALUE;
         end
      end else if (o.sel < SEL_KC0_LO) begin
         r.kind = K_GPR;
         idx = (o.index_mode == IDX_LOOP) ? lp : a.x;
         s = o.rel ? idx_sum({2'b00, o.sel[6:0]}, idx)
                   : $signed({4'b0000, o.sel[6:0]});
         r.addr = {2'b00, s[6:0]};
         // Temp range bases are never indexed, so only in-range bases
         // are checked here
         if (o.rel && (o.sel[6:0] < n) &&
             (s < 0 || s >= $signed({4'b0000, n}))) begin
            r.oob  = 1'b1;
            r.addr = 9'h000;
            r.wr   = o.is_dest && o.mem_read;
         end
      end else if (o.sel <= SEL_KC1_HI) begin
         r.kind = K_KC;
         bank1 = (o.sel >= SEL_KC1_LO);
         off = bank1 ? (o.sel - SEL_KC1_LO) : (o.sel - SEL_KC0_LO);
         s = o.rel ? idx_sum(off, lp) : $signed({2'b00, off});
         r.addr = {5'h00, s[3:0]};
         r.kc_buffer = bank1 ? c.buf1 : c.buf0;
         r.kc_line = (bank1 ? c.line1 : c.line0) +
                     ((bank1 ? c.loop_rel1 : c.loop_rel0) ? lp[7:0] : 8'h00) +
                     {7'h00, s[4]};
         r.alt_bank = c.alt && c.paired_kind;
         if (o.rel && ((c.lock_mode == LOCK_ONE &&
                        (s < 0 || s > KC1_LAST)) ||
                       (c.lock_mode == LOCK_TWO &&
                        (s < 0 || s > KC2_LAST)))) begin
            r.oob       = 1'b1;
            r.rd        = 1'b0;
            r.use_const = 1'b1;
            r.const_val = NAN_VALUE;
         end
      end else if (o.sel == SEL_PREV_S) begin
         r.kind = K_PS;
         r.elem = 2'h0;
      end else if (o.sel == SEL_PREV_V) begin
         r.kind = K_PV;
      end else if (o.sel == SEL_LITERAL) begin
         r.kind    = K_LIT;
         r.addr    = {7'h00, o.elem};
         r.lit_two = o.elem[1];
      end else begin
         r.kind      = K_INL;
         r.rd        = 1'b0;
         r.use_const = 1'b1;
         case (o.sel)
            SEL_ONE_F:  r.const_val = VAL_ONE_F;
            SEL_ONE_I:  r.const_val = VAL_ONE_I;
            SEL_MONE_I: r.const_val = VAL_MONE_I;
            SEL_HALF_F: r.const_val = VAL_HALF_F;
            default:    r.const_val = VAL_ZERO;
         endcase
      end
      resolve = r;
   endfunction

   //==========================================================
   // Issue control
   assign uses_ar  = needs_ar(op);
   assign ar_stall = uses_ar && (ar_age < AR_DELAY);
   assign op_ready = (state == S_IDLE) && !ar_stall;
   assign accept   = op_valid && op_ready;
   assign start_wf = accept && op.per_lane && op.sel[8] && uses_ar;
   assign issue    = (accept && !start_wf) || (state == S_WFALL);
   assign cur_op   = (state == S_WFALL) ? wf_op : op;
   assign lane_sel = lane;
   assign lane_idx = lane_index;

   // Decode of the operand presented this cycle
   always_comb begin
      next_res      = resolve(cur_op, ar, loop_index, lane_idx, gpr_count, clause);
      next_res.lane = (state == S_WFALL) ? lane : 6'h00;
   end

   // Waterfall state: one constant-file read per lane
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (start_wf) begin
               next_state = S_WFALL;
            end
         end
         S_WFALL: begin
            if (lane == LANE_LAST) begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Lane counter and the held operand for the waterfall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane  <= 6'h00;
         wf_op <= '0;
      end else begin
         if (start_wf) begin
            wf_op <= op;
         end
         if (state == S_WFALL) begin
            lane <= lane + 6'h01;
         end else begin
            lane <= 6'h00;
         end
      end
   end

   //==========================================================
   // Clause state: lock mode, groups, address register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clause        <= '0;
         clause_active <= 1'b0;
      end else if (clause_start) begin
         clause        <= clause_cfg;
         clause_active <= 1'b1;
      end else if (clause_end) begin
         clause_active <= 1'b0;
      end
   end

   // Stall cycles count as elapsed instruction slots, so the gap
   // is met whether the program leaves it or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ar       <= '0;
         ar_valid <= 1'b0;
         ar_age   <= 2'h0;
      end else if (clause_end || clause_start) begin
         ar       <= '0;
         ar_valid <= 1'b0;
         ar_age   <= 2'h0;
      end else if (ar_load) begin
         ar       <= ar_value;
         ar_valid <= 1'b1;
         ar_age   <= 2'h0;
      end else if (ar_age < AR_DELAY &&
                   ((accept && op.last) || (op_valid && ar_stall))) begin
         ar_age <= ar_age + 2'h1;
      end
   end

   //==========================================================
   // Storage request register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid <= 1'b0;
         res       <= '0;
      end else begin
         res_valid <= issue;
         if (issue) begin
            res <= next_res;
         end
      end
   end

   // Operand return alignment: storage answers two cycles after issue, the cycle after res_valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend       <= 1'b0;
         pend_const <= 1'b0;
         pend_raw   <= 1'b0;
         pend_val   <= 32'h00000000;
         pend_neg   <= 1'b0;
         pend_abs   <= 1'b0;
      end else begin
         pend       <= res_valid && !res.wr;
         pend_const <= res.use_const;
         pend_raw   <= res.oob && res.use_const;
         pend_val   <= res.const_val;
         pend_neg   <= res.neg;
         pend_abs   <= res.abs;
      end
   end

   assign mod_valid = pend && (pend_const || ret_valid);

   aosr_modifier u_modifier (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (mod_valid),
      .in_data   (pend_const ? pend_val : ret_data),
      .in_neg    (pend_neg),
      .in_abs    (pend_abs),
      .in_raw    (pend_raw),
      .out_valid (operand_valid),
      .out_data  (operand_data)
   );

   //==========================================================
   // APB slave: zero wait states, error on unmapped offsets
   assign apb_wr  = psel && penable && pwrite;
   assign apb_rd  = psel && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable &&
                    !(paddr == REG_CONFIG || paddr == REG_STATUS ||
                      paddr == REG_STALLS || paddr == REG_OOB);

   // Declared register count steers the register bounds check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpr_count <= GPR_COUNT_RST;
      end else if (apb_wr && paddr == REG_CONFIG) begin
         gpr_count <= pwdata[6:0];
      end
   end

   // Event counters; a software write of any value clears them unless an event counts in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_count <= 16'h0000;
         oob_count   <= 16'h0000;
      end else begin
         if (op_valid && ar_stall && state == S_IDLE) begin
            stall_count <= stall_count + 16'h0001;
         end else if (apb_wr && paddr == REG_STALLS) begin
            stall_count <= 16'h0000;
         end
         if (issue && next_res.oob) begin
            oob_count <= oob_count + 16'h0001;
         end else if (apb_wr && paddr == REG_OOB) begin
            oob_count <= 16'h0000;
         end
      end
   end

   // Read data, held in a register for the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_rd && !penable) begin
         case (paddr)
            REG_CONFIG: prdata <= {25'h0000000, gpr_count};
            REG_STATUS: prdata <= {24'h000000, state == S_WFALL,
                                   clause.alt, clause.lock_mode,
                                   clause_active, ar_age, ar_valid};
            REG_STALLS: prdata <= {16'h0000, stall_count};
            REG_OOB:    prdata <= {16'h0000, oob_count};
            default:    prdata <= 32'h00000000;
         endcase
      end
   end
endmodule

//--- verif/aosr_monitor.sv
// Checker: port-level assertions for the operand resolver
`timescale 1ns/10ps
module aosr_monitor import aosr_pkg::*; (
   // Clock and reset
   input wire logic      pclk,
   input wire logic      presetn,
   // Operand side
   input wire logic      ar_load,
   input wire logic      op_valid,
   input wire aosr_op_t  op,
   input wire logic      op_ready,
   input wire logic      res_valid,
   input wire aosr_res_t res,
   input wire logic      operand_valid
);
   //=====
   // Accepted request; a waterfall start issues its first lane a cycle later
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = op_valid && op_ready && !op.two_src_enc &&
              !(op.per_lane && op.sel[8] && op.rel && op.index_mode != IDX_LOOP);
   chk_res_follows:
      assert property (acc |=> res_valid) else $error("no request after accept");
   chk_read_zero:
      assert property (res_valid && res.kind == K_GPR && res.rd && res.oob |-> res.addr == 9'h000)
         else $error("stray read not sent to register zero");
   chk_write_drop:
      assert property ($past(acc && op.is_dest && !op.mem_read) && res_valid && res.oob |-> !res.wr)
         else $error("stray write not inhibited");
   chk_memrd_zero:
      assert property ($past(acc && op.is_dest && op.mem_read) && res_valid && res.oob
         |-> res.wr && res.addr == 9'h000) else $error("memory read result not in register zero");
   chk_cf_nan:
      assert property (res_valid && res.kind == K_CF && res.oob |-> res.const_val == NAN_VALUE)
         else $error("constant file overrun not NaN");
   chk_kc_nan:
      assert property (res_valid && res.kind == K_KC && res.oob |-> res.const_val == NAN_VALUE)
         else $error("cache overrun not NaN");
   chk_abs_addr:
      assert property ($past(acc && !op.rel && op.sel < 9'h080) |-> res.addr == $past(op.sel))
         else $error("absolute register address altered");
   chk_ar_stall:
      assert property ($past(ar_load) && op_valid && op.rel && op.index_mode < IDX_LOOP |-> !op_ready)
         else $error("index used right after load");
   chk_oper_lag:
      assert property (res_valid && res.rd && !res.use_const |-> ##2 operand_valid)
         else $error("operand late");
endmodule

//--- verif/aosr_store_model.sv
// Storage model: answers each read request one cycle later
`timescale 1ns/10ps
module aosr_store_model import aosr_pkg::*; (
   // Clock, reset and request
   input wire logic      pclk,
   input wire logic      presetn,
   input wire logic      res_valid,
   input wire aosr_res_t res,
   // Answer
   output logic          ret_valid,
   output logic [31:0]   ret_data
);
   //=====
   // Negative data makes modifier order visible; idle data toggles so it never looks fresh
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ret_valid <= 1'b0;
         ret_data  <= 32'h5A5A5A5A;
      end else begin
         ret_valid <= res_valid && res.rd;
         ret_data  <= (res_valid && res.rd) ? (32'hC0000000 | 32'(res.addr)) : ~ret_data;
      end
   end
endmodule

//--- verif/aosr_resolver_test.sv
// Testbench: APB and operand scenarios for the operand resolver
`timescale 1ns/10ps
module aosr_resolver_test;
   import aosr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ar_load = 0;
   logic clause_start = 0, clause_end = 0, op_valid = 0, pready, pslverr, err;
   logic res_valid, ret_valid, operand_valid, op_ready;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, ret_data, operand_data, rd;
   logic [5:0] lane_sel;
   aosr_clause_t cfg = '0;
   aosr_ar_t ar = '{x:9'h001, default:'0};
   aosr_op_t op = '0;
   aosr_res_t res;
   int fail_count = 0, num_checks = 0, cyc = 0, st;
   aosr_resolver i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clause_start(clause_start), .clause_end(clause_end),
      .clause_cfg(cfg), .ar_load(ar_load), .ar_value(ar), .loop_index(9'h005),
      .lane_index(9'h000), .lane_sel(lane_sel), .op_valid(op_valid), .op(op),
      .op_ready(op_ready), .res_valid(res_valid), .res(res), .ret_valid(ret_valid),
      .ret_data(ret_data), .operand_valid(operand_valid), .operand_data(operand_data));
   aosr_store_model i_store (.pclk(pclk), .presetn(presetn), .res_valid(res_valid),
      .res(res), .ret_valid(ret_valid), .ret_data(ret_data));
   //=====
   // Tasks
   task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Request held until pready is seen high at a rising edge; data taken there
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic clause(logic [1:0] m);
      @(posedge pclk);
      clause_end <= 1;
      @(posedge pclk);
      clause_end <= 0;
      clause_start <= 1;
      cfg <= '{lock_mode:m, default:'0};
      @(posedge pclk);
      clause_start <= 0;
   endtask
   // f = {dest, memory read, negate, absolute}; counts refused cycles in st
   task automatic issue(logic [8:0] s, logic r, logic [3:0] f, logic [2:0] m = IDX_LOOP);
      @(posedge pclk);
      ar_load <= 0;
      op_valid <= 1;
      op <= '{sel:s, rel:r, index_mode:m, is_dest:f[3], mem_read:f[2], neg:f[1],
              abs:f[0], last:1, default:'0};
      st = 0;
      // Ready is read at the edge, before that edge's updates land
      @(posedge pclk);
      while (op_ready !== 1'b1) begin
         st++;
         @(posedge pclk);
      end
      op_valid <= 0;
      @(negedge pclk);
      chk("res_valid", 32'(res_valid), 1);
   endtask
   //=====
   // Clock, timeout, main sequence
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (++cyc == 3000) begin
      fail_count++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      apb(0, REG_CONFIG, 0);
      chk("config reset", rd, 32'(GPR_COUNT_RST));
      apb(1, REG_CONFIG, 32'h8);
      apb(0, REG_CONFIG, 0);
      chk("config", rd, 32'h8);
      apb(0, 12'h010, 0);
      chk("unmapped", 32'(err), 1);
      // Program side: no indexed temporaries, few constants, no literals
      clause(LOCK_ONE);
      issue(9'h002, 1, 0); // Base inside declared range
      chk("rel add", 32'(res.addr), 7);
      issue(9'h004, 1, 4'h3);
      chk("oob read", 32'(res.addr), 0);
      repeat (2) @(negedge pclk);
      chk("abs neg", operand_data, 32'hC0000000);
      issue(9'h003, 0, 4'h2);
      chk("abs addr", 32'(res.addr), 3);
      repeat (2) @(negedge pclk);
      chk("neg", operand_data, 32'h40000003);
      issue(9'h004, 1, 4'h8);
      chk("write drop", 32'(res.wr), 0);
      issue(9'h004, 1, 4'hC);
      chk("memrd", 32'({res.wr, res.addr}), 32'h200);
      issue(9'h1FC, 1, 0);
      chk("cf nan", res.const_val, NAN_VALUE);
      issue(9'h08C, 1, 0); // Only the locked line is used
      chk("kc1 nan", res.const_val, NAN_VALUE);
      clause(LOCK_TWO);
      issue(9'h08C, 1, 0);
      chk("kc2 in", 32'(res.use_const), 0);
      issue(9'h09C, 1, 0);
      chk("kc2 nan", res.const_val, NAN_VALUE);
      @(posedge pclk);
      ar_load <= 1;
      issue(9'h002, 1, 0, 3'h0);
      chk("stalls", st, 32'(AR_DELAY));
      chk("ar x", 32'(res.addr), 3);
      apb(0, REG_STALLS, 0);
      chk("stall count", rd, 32'h2);
      apb(0, REG_OOB, 0);
      chk("oob count", rd, 32'h6);
      apb(0, REG_STATUS, 0);
      chk("status", rd, 32'h2D);
      clause(LOCK_NONE);
      apb(0, REG_STATUS, 0);
      chk("status cleared", rd, 32'h08);
      repeat (4) @(posedge pclk);
      test_done();
   end
endmodule
bind aosr_resolver aosr_monitor i_mon (.pclk(pclk), .presetn(presetn), .ar_load(ar_load),
   .op_valid(op_valid), .op(op), .op_ready(op_ready), .res_valid(res_valid), .res(res),
   .operand_valid(operand_valid));
